// *** shared/tmcc_pkg.sv ***
// Package for the 16-bit timer mode, clock select and capture control block.
// Assumes a single 100 MHz clock and a byte-wide register port.
package tmcc_pkg;

	// Register offsets
	localparam logic [7:0] TMCC_ADDR_CTRL_A  = 8'h90;
	localparam logic [7:0] TMCC_ADDR_CTRL_B  = 8'h91;
	localparam logic [7:0] TMCC_ADDR_CNT_L   = 8'h94;
	localparam logic [7:0] TMCC_ADDR_CNT_H   = 8'h95;
	localparam logic [7:0] TMCC_ADDR_CAP_L   = 8'h96;
	localparam logic [7:0] TMCC_ADDR_CAP_H   = 8'h97;
	localparam logic [7:0] TMCC_ADDR_CMPA_L  = 8'h98;
	localparam logic [7:0] TMCC_ADDR_CMPA_H  = 8'h99;
	localparam logic [7:0] TMCC_ADDR_STATUS  = 8'ha0;
	localparam logic [7:0] TMCC_ADDR_MASK    = 8'ha1;

	// Reset values
	localparam logic [7:0]  TMCC_RST_BYTE    = 8'h00;
	localparam logic [15:0] TMCC_RST_WORD    = 16'h0000;

	// Field positions in control register B
	localparam int TMCC_B_FILTER   = 7;
	localparam int TMCC_B_EDGE     = 6;
	localparam int TMCC_B_WM3      = 4;
	localparam int TMCC_B_WM2      = 3;
	// Status and mask bit positions
	localparam int TMCC_ST_OVF     = 0;
	localparam int TMCC_ST_CAP     = 5;
	localparam logic [7:0] TMCC_ST_IMPL = 8'h21;

	// Fixed TOP values
	localparam logic [15:0] TMCC_TOP_MAX  = 16'hffff;
	localparam logic [15:0] TMCC_TOP_8    = 16'h00ff;
	localparam logic [15:0] TMCC_TOP_9    = 16'h01ff;
	localparam logic [15:0] TMCC_TOP_10   = 16'h03ff;
	localparam logic [15:0] TMCC_BOTTOM   = 16'h0000;

	// Prescaler taps
	localparam int TMCC_DIV_8     = 8;
	localparam int TMCC_DIV_64    = 64;
	localparam int TMCC_DIV_256   = 256;
	localparam int TMCC_DIV_1024  = 1024;
	localparam int TMCC_PRE_W     = 10;
	localparam int TMCC_FILT_LEN  = 4;

	// Clock select codes
	localparam logic [2:0] TMCC_CS_STOP  = 3'h0;
	localparam logic [2:0] TMCC_CS_DIV1  = 3'h1;
	localparam logic [2:0] TMCC_CS_DIV8  = 3'h2;
	localparam logic [2:0] TMCC_CS_DIV64 = 3'h3;
	localparam logic [2:0] TMCC_CS_DIV256 = 3'h4;
	localparam logic [2:0] TMCC_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TMCC_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] TMCC_CS_EXT_RISE = 3'h7;

	// Decoded behaviour of one wave mode
	typedef enum logic [1:0] {
		TMCC_TOP_FIXED,
		TMCC_TOP_CMPA,
		TMCC_TOP_CAP
	} tmcc_top_src_type;

	typedef enum logic [2:0] {
		TMCC_WF_NORMAL,
		TMCC_WF_CTC,
		TMCC_WF_FAST,
		TMCC_WF_PHASE,
		TMCC_WF_PFC,
		TMCC_WF_RSVD
	} tmcc_wave_type;

	typedef struct packed {
		tmcc_wave_type    wave;
		tmcc_top_src_type top_src;
		logic [15:0]      top_fixed;
	} tmcc_mode_type;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tmcc_bus_req_type;

endpackage

// *** rtl/tmcc_capture_filter.sv ***
// Capture pin noise filter with a run-length of equal samples.
// Assumes the pin is already synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module tmcc_capture_filter
	import tmcc_pkg::*;
#(
	parameter int LEN = TMCC_FILT_LEN
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic enable,
	input  wire logic pin_in,
	output var  logic level_out
);
	logic [LEN-2:0] hist_q;
	logic           filt_q;
	// Past samples plus the live pin, so the run adds no extra register
	wire  logic [LEN-1:0] run = {hist_q, pin_in};
	wire  logic     all_one  = &run;
	wire  logic     all_zero = ~|run;

	// Shift history; output moves only on a full run
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hist_q <= '0;
			filt_q <= 1'b0;
		end else begin
			hist_q <= run[LEN-2:0];
			if (all_one)
				filt_q <= 1'b1;
			else if (all_zero)
				filt_q <= 1'b0;
		end
	end

	// Bypass gives the raw pin, so no filter delay
	assign level_out = enable ? filt_q : pin_in;
endmodule
`default_nettype wire

// *** rtl/tmcc_timer_ctrl.sv ***
// Summary of operation
// - Wave mode is two low bits of ctrl A and bits 4 and 3 of ctrl B.
// - Normal, clear-on-compare, fast, phase correct and phase-frequency modes.
// - TOP per mode: fixed 8/9/10/16 bit, compare A or capture value.
// - Filter changes only after four equal successive capture samples.
// - Edge select zero captures falling edges, one captures rising edges.
// - Capture copies the counter and sets the capture flag.
// - Capture pin ignored while capture value is TOP.
// - Clock select 0 stops, 1 undivided, 2..4 divide by 8, 64, 256.
// - Clock select 5 divides by 1024; 6 and 7 use external pin edges.
//
// Timer control: mode decode, prescaler, counter, capture and interrupts.
// Assumes a byte register port and pins synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module tmcc_timer_ctrl
	import tmcc_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output var  logic [7:0]       reg_rdata,
	input  wire logic             capture_pin,
	input  wire logic             ext_clock_pin,
	output var  logic [WIDTH-1:0] count_value,
	output var  logic [WIDTH-1:0] compare_active,
	output var  logic             irq
);
	tmcc_bus_req_type bus;
	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// Software registers
	logic [7:0]       ctrl_a_q;
	logic [7:0]       ctrl_b_q;
	logic [7:0]       status_q;
	logic [7:0]       mask_q;
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cap_q;
	logic [WIDTH-1:0] cmpa_buf_q;
	logic [WIDTH-1:0] cmpa_q;
	logic             dir_down_q;
	logic [7:0]       rdata_q;
	logic [TMCC_PRE_W-1:0] pre_q;
	logic             ext_q;
	logic             capf_q;

	// Field decode
	wire logic [3:0] wave_mode = {ctrl_b_q[TMCC_B_WM3], ctrl_b_q[TMCC_B_WM2],
		ctrl_a_q[1:0]};
	wire logic [2:0] clock_source_sel = ctrl_b_q[2:0];
	wire logic       capture_filter_en = ctrl_b_q[TMCC_B_FILTER];
	wire logic       capture_edge_sel  = ctrl_b_q[TMCC_B_EDGE];

	// Mode table as a function, one entry per code
	function automatic tmcc_mode_type mode_decode(input logic [3:0] m);
		tmcc_mode_type r;
		r = '{wave: TMCC_WF_NORMAL, top_src: TMCC_TOP_FIXED,
			top_fixed: TMCC_TOP_MAX};
		case (m)
			4'h0: r.wave = TMCC_WF_NORMAL;
			4'h1: r = '{TMCC_WF_PHASE, TMCC_TOP_FIXED, TMCC_TOP_8};
			4'h2: r = '{TMCC_WF_PHASE, TMCC_TOP_FIXED, TMCC_TOP_9};
			4'h3: r = '{TMCC_WF_PHASE, TMCC_TOP_FIXED, TMCC_TOP_10};
			4'h4: r = '{TMCC_WF_CTC, TMCC_TOP_CMPA, TMCC_TOP_MAX};
			4'h5: r = '{TMCC_WF_FAST, TMCC_TOP_FIXED, TMCC_TOP_8};
			4'h6: r = '{TMCC_WF_FAST, TMCC_TOP_FIXED, TMCC_TOP_9};
			4'h7: r = '{TMCC_WF_FAST, TMCC_TOP_FIXED, TMCC_TOP_10};
			4'h8: r = '{TMCC_WF_PFC, TMCC_TOP_CAP, TMCC_TOP_MAX};
			4'h9: r = '{TMCC_WF_PFC, TMCC_TOP_CMPA, TMCC_TOP_MAX};
			4'ha: r = '{TMCC_WF_PHASE, TMCC_TOP_CAP, TMCC_TOP_MAX};
			4'hb: r = '{TMCC_WF_PHASE, TMCC_TOP_CMPA, TMCC_TOP_MAX};
			4'hc: r = '{TMCC_WF_CTC, TMCC_TOP_CAP, TMCC_TOP_MAX};
			4'hd: r.wave = TMCC_WF_RSVD;
			4'he: r = '{TMCC_WF_FAST, TMCC_TOP_CAP, TMCC_TOP_MAX};
			4'hf: r = '{TMCC_WF_FAST, TMCC_TOP_CMPA, TMCC_TOP_MAX};
			default: r.wave = TMCC_WF_RSVD;
		endcase
		return r;
	endfunction

	tmcc_mode_type mode;
	assign mode = mode_decode(wave_mode);

	wire logic [WIDTH-1:0] top_value =
		(mode.top_src == TMCC_TOP_CMPA) ? cmpa_q :
		(mode.top_src == TMCC_TOP_CAP)  ? cap_q  :
		mode.top_fixed[WIDTH-1:0];

	wire logic immediate_mode = (mode.wave == TMCC_WF_NORMAL) ||
		(mode.wave == TMCC_WF_CTC) || (mode.wave == TMCC_WF_RSVD);
	wire logic updown_mode = (mode.wave == TMCC_WF_PHASE) ||
		(mode.wave == TMCC_WF_PFC);
	wire logic capture_disc = (mode.top_src == TMCC_TOP_CAP);

	// Free-running prescaler; taps give one-cycle enables
	wire logic tap8    = (pre_q[2:0] == 3'h7);
	wire logic tap64   = (pre_q[5:0] == 6'h3f);
	wire logic tap256  = (pre_q[7:0] == 8'hff);
	wire logic tap1024 = (pre_q[9:0] == 10'h3ff);
	wire logic ext_rise = ext_clock_pin & ~ext_q;
	wire logic ext_fall = ~ext_clock_pin & ext_q;

	logic tick;
	// Clock select decode
	always_comb begin
		case (clock_source_sel)
			TMCC_CS_STOP:     tick = 1'b0;
			TMCC_CS_DIV1:     tick = 1'b1;
			TMCC_CS_DIV8:     tick = tap8;
			TMCC_CS_DIV64:    tick = tap64;
			TMCC_CS_DIV256:   tick = tap256;
			TMCC_CS_DIV1024:  tick = tap1024;
			TMCC_CS_EXT_FALL: tick = ext_fall;
			TMCC_CS_EXT_RISE: tick = ext_rise;
			default:          tick = 1'b0;
		endcase
	end

	// Counter sequencing
	wire logic at_top    = (cnt_q == top_value);
	wire logic at_bottom = (cnt_q == TMCC_BOTTOM[WIDTH-1:0]);
	wire logic at_max    = (cnt_q == TMCC_TOP_MAX[WIDTH-1:0]);
	logic [WIDTH-1:0] cnt_next;
	logic             dir_next;
	always_comb begin
		cnt_next = cnt_q + 1'b1;
		dir_next = dir_down_q;
		if (updown_mode) begin
			if (!dir_down_q && at_top) begin
				dir_next = 1'b1;
				cnt_next = cnt_q - 1'b1;
			end else if (dir_down_q && at_bottom) begin
				dir_next = 1'b0;
			end else if (dir_down_q) begin
				cnt_next = cnt_q - 1'b1;
			end
		end else if (mode.wave != TMCC_WF_NORMAL && at_top) begin
			cnt_next = TMCC_BOTTOM[WIDTH-1:0];
		end
	end

	// Overflow point per family
	wire logic ovf_event = tick && (immediate_mode ? at_max :
		(mode.wave == TMCC_WF_FAST) ? at_top :
		(at_bottom && dir_down_q));
	// Compare buffer load point per family
	wire logic cmp_load = immediate_mode ? 1'b1 :
		(mode.wave == TMCC_WF_PHASE) ? (tick && at_top) :
		(tick && at_bottom);

	// Capture path
	logic cap_level;
	tmcc_capture_filter #(
		.LEN(TMCC_FILT_LEN)
	) u_filter (
		.clock    (clock),
		.nrst     (nrst),
		.enable   (capture_filter_en),
		.pin_in   (capture_pin),
		.level_out(cap_level)
	);
	wire logic cap_edge = capture_edge_sel ? (cap_level & ~capf_q) :
		(~cap_level & capf_q);
	wire logic cap_event = cap_edge && !capture_disc;
	// With capture value as TOP the flag marks reaching TOP instead
	wire logic capf_event = cap_event || (capture_disc && tick && at_top);

	// Register writes decoded
	wire logic wr_a    = bus.wr && (bus.addr == TMCC_ADDR_CTRL_A);
	wire logic wr_b    = bus.wr && (bus.addr == TMCC_ADDR_CTRL_B);
	wire logic wr_cl   = bus.wr && (bus.addr == TMCC_ADDR_CNT_L);
	wire logic wr_ch   = bus.wr && (bus.addr == TMCC_ADDR_CNT_H);
	wire logic wr_pl   = bus.wr && (bus.addr == TMCC_ADDR_CAP_L);
	wire logic wr_ph   = bus.wr && (bus.addr == TMCC_ADDR_CAP_H);
	wire logic wr_ml   = bus.wr && (bus.addr == TMCC_ADDR_CMPA_L);
	wire logic wr_mh   = bus.wr && (bus.addr == TMCC_ADDR_CMPA_H);
	wire logic wr_st   = bus.wr && (bus.addr == TMCC_ADDR_STATUS);
	wire logic wr_mask = bus.wr && (bus.addr == TMCC_ADDR_MASK);

	// Events set, write-one clears; set wins
	logic [7:0] ev_set;
	always_comb begin
		ev_set = TMCC_RST_BYTE;
		ev_set[TMCC_ST_OVF] = ovf_event;
		ev_set[TMCC_ST_CAP] = capf_event;
	end
	wire logic [7:0] status_d = ((status_q & ~(wr_st ? bus.wdata :
		TMCC_RST_BYTE)) | ev_set) & TMCC_ST_IMPL;

	// Control and status registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_a_q <= TMCC_RST_BYTE;
			ctrl_b_q <= TMCC_RST_BYTE;
			status_q <= TMCC_RST_BYTE;
			mask_q   <= TMCC_RST_BYTE;
		end else begin
			if (wr_a)
				ctrl_a_q <= bus.wdata;
			if (wr_b)
				ctrl_b_q <= bus.wdata & 8'hdf; // Bit 5 reserved
			if (wr_mask)
				mask_q <= bus.wdata & TMCC_ST_IMPL;
			status_q <= status_d;
		end
	end

	// Counter, direction, prescaler and edge history
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_q      <= TMCC_RST_WORD;
			dir_down_q <= 1'b0;
			pre_q      <= '0;
			ext_q      <= 1'b0;
			capf_q     <= 1'b0;
		end else begin
			pre_q  <= pre_q + 1'b1;
			ext_q  <= ext_clock_pin;
			capf_q <= cap_level;
			if (wr_cl)
				cnt_q[7:0] <= bus.wdata;
			else if (wr_ch)
				cnt_q[15:8] <= bus.wdata;
			else if (tick) begin
				cnt_q      <= cnt_next;
				dir_down_q <= dir_next;
			end
		end
	end

	// Capture and compare registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cap_q      <= TMCC_RST_WORD;
			cmpa_buf_q <= TMCC_RST_WORD;
			cmpa_q     <= TMCC_RST_WORD;
		end else begin
			if (cap_event)
				cap_q <= cnt_q;
			else if (wr_pl)
				cap_q[7:0] <= bus.wdata;
			else if (wr_ph)
				cap_q[15:8] <= bus.wdata;
			if (wr_ml)
				cmpa_buf_q[7:0] <= bus.wdata;
			if (wr_mh)
				cmpa_buf_q[15:8] <= bus.wdata;
			if (cmp_load)
				cmpa_q <= cmpa_buf_q;
		end
	end

	// Read mux; unmapped addresses read zero
	logic [7:0] rd_mux;
	always_comb begin
		case (bus.addr)
			TMCC_ADDR_CTRL_A: rd_mux = ctrl_a_q;
			TMCC_ADDR_CTRL_B: rd_mux = ctrl_b_q;
			TMCC_ADDR_CNT_L:  rd_mux = cnt_q[7:0];
			TMCC_ADDR_CNT_H:  rd_mux = cnt_q[15:8];
			TMCC_ADDR_CAP_L:  rd_mux = cap_q[7:0];
			TMCC_ADDR_CAP_H:  rd_mux = cap_q[15:8];
			TMCC_ADDR_CMPA_L: rd_mux = cmpa_buf_q[7:0];
			TMCC_ADDR_CMPA_H: rd_mux = cmpa_buf_q[15:8];
			TMCC_ADDR_STATUS: rd_mux = status_q;
			TMCC_ADDR_MASK:   rd_mux = mask_q;
			default:          rd_mux = TMCC_RST_BYTE;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			rdata_q <= TMCC_RST_BYTE;
		else
			rdata_q <= bus.rd ? rd_mux : TMCC_RST_BYTE;
	end

	assign reg_rdata      = rdata_q;
	assign count_value    = cnt_q;
	assign compare_active = cmpa_q;
	assign irq            = |(status_q & mask_q);
endmodule
`default_nettype wire

// *** dv/tmcc_pins_model.sv ***
// Far side pins: capture input and external count clock.
// Assumes the bench steers levels just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module tmcc_pins_model (
	input  wire logic clock,
	input  wire logic cap_level,
	input  wire logic ext_run,
	output var  logic capture_pin,
	output var  logic ext_clock_pin
);
	logic [1:0] ph_q;
	initial begin
		capture_pin = 1'b0;
		ext_clock_pin = 1'b0;
		ph_q = 2'h0;
	end
	// Pin follows the bench one edge late; clock stands still when idle
	always @(posedge clock) begin
		capture_pin <= cap_level;
		ph_q <= (ext_run && ph_q != 2'h2) ? ph_q + 2'h1 : 2'h0;
		if (ext_run && ph_q == 2'h2) begin
			ext_clock_pin <= !ext_clock_pin;
		end
	end
endmodule
`default_nettype wire

// *** dv/tmcc_timer_ctrl_monitor.sv ***
// Checker for the timer control block, bound to its top module.
// Assumes control bytes change only through register writes.
`timescale 1ns/1ps
`default_nettype none
module tmcc_timer_ctrl_monitor
	import tmcc_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic             clock,
	input wire logic             nrst,
	input wire logic [7:0]       reg_addr,
	input wire logic [7:0]       reg_wdata,
	input wire logic             reg_wr,
	input wire logic             reg_rd,
	input wire logic [7:0]       reg_rdata,
	input wire logic             capture_pin,
	input wire logic             ext_clock_pin,
	input wire logic [WIDTH-1:0] count_value,
	input wire logic [WIDTH-1:0] compare_active,
	input wire logic             irq
);
	logic [7:0] ca_q;
	logic [7:0] cb_q;
	// Shadow of the control bytes as software wrote them
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ca_q <= 8'h00;
			cb_q <= 8'h00;
		end else if (reg_wr && reg_addr == TMCC_ADDR_CTRL_A) begin
			ca_q <= reg_wdata;
		end else if (reg_wr && reg_addr == TMCC_ADDR_CTRL_B) begin
			cb_q <= reg_wdata;
		end
	end
	// Decoded view; count writes override ticks so they are excluded
	wire logic [3:0] mode = {cb_q[4:3], ca_q[1:0]};
	wire logic [2:0] csel = cb_q[2:0];
	wire logic       cwr  = reg_wr && reg_addr[7:1] == 7'h4a;
	wire logic       pwr  = reg_wr && reg_addr == TMCC_ADDR_CMPA_L;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_CTRLB_READ: assert property (reg_rd && reg_addr == TMCC_ADDR_CTRL_B
		|=> reg_rdata == {cb_q[7:6], 1'b0, cb_q[4:0]})
		else $error("control B read back wrong");
	AST_RST_STOP: assert property ($rose(nrst) |-> count_value == 16'h0000)
		else $error("counter not zero after reset");
	AST_STOP_HOLD: assert property (csel == 3'h0 && $past(csel) == 3'h0
		&& !cwr |=> $stable(count_value))
		else $error("stopped counter moved");
	AST_DIV1_STEP: assert property (csel == 3'h1 && mode == 4'h0
		&& $stable(cb_q) && $stable(ca_q) && !cwr
		|=> count_value == $past(count_value) + 16'h0001)
		else $error("undivided clock did not step by one");
	AST_FAST8_TOP: assert property (mode == 4'h5 && $stable(cb_q)
		&& count_value <= 16'h00ff && !cwr |=> count_value <= 16'h00ff)
		else $error("8-bit fast mode passed its top");
	AST_CMP_IMMED: assert property (mode == 4'h0 && pwr
		|-> ##2 compare_active[7:0] == $past(reg_wdata, 2))
		else $error("compare not loaded at once in normal mode");
	AST_CMP_HELD: assert property (mode == 4'h5 && pwr
		&& count_value > 16'h0010 && count_value < 16'h00f0
		|=> $stable(compare_active))
		else $error("compare loaded away from bottom");
	AST_EXT_QUIET: assert property ($stable(ext_clock_pin)[*4]
		##0 (csel[2:1] == 2'h3 && $past(csel[2:1]) == 2'h3 && !cwr)
		|=> $stable(count_value))
		else $error("counter moved without an external edge");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(reg_wr))
		else $error("interrupt dropped without a write");
	COV_IRQ: cover property ($rose(irq));
	COV_EXT: cover property (csel == 3'h7 && $changed(count_value));
	COV_FAST: cover property (mode == 4'h5 && count_value == 16'h00ff);
endmodule
bind tmcc_timer_ctrl tmcc_timer_ctrl_monitor #(.WIDTH(WIDTH)) i_mon (
	.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .capture_pin(capture_pin),
	.ext_clock_pin(ext_clock_pin), .count_value(count_value),
	.compare_active(compare_active), .irq(irq));
`default_nettype wire

// *** dv/tmcc_timer_ctrl_tb.sv ***
// Self-checking bench for the timer control block.
// Assumes the pin model on the far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tmcc_timer_ctrl_tb
	import tmcc_pkg::*;
;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        cap_level = 1'b0;
	logic        ext_run = 1'b0;
	logic [7:0]  reg_rdata;
	logic        capture_pin;
	logic        ext_clock_pin;
	logic [15:0] count_value;
	logic [15:0] compare_active;
	logic        irq;
	logic [15:0] c0;
	logic [7:0]  rv;
	int          n;
	int          num_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	always #5 clock = ~clock;
	tmcc_timer_ctrl i_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .capture_pin(capture_pin),
		.ext_clock_pin(ext_clock_pin), .count_value(count_value),
		.compare_active(compare_active), .irq(irq));
	tmcc_pins_model i_pins (.clock(clock), .cap_level(cap_level),
		.ext_run(ext_run), .capture_pin(capture_pin),
		.ext_clock_pin(ext_clock_pin));
	task automatic final_report();
		$display("compares %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Hang guard, well above the longest expected run
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// Register port cycles; strobes last one cycle
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// Stop, load mode, clear count, then start with the given clock
	task automatic setm(logic [3:0] m, logic [2:0] cs, logic [1:0] fe);
		wr(TMCC_ADDR_CTRL_B, 8'h00);
		wr(TMCC_ADDR_CTRL_A, {6'h00, m[1:0]});
		wr(TMCC_ADDR_CNT_H, 8'h00);
		wr(TMCC_ADDR_CNT_L, 8'h00);
		wr(TMCC_ADDR_CTRL_B, {fe, 1'b0, m[3:2], cs});
	endtask
	// Move the capture level, then wait a bounded time for the interrupt
	task automatic drive(logic lvl, output int k);
		@(posedge clock);
		cap_level <= lvl;
		#1 c0 = count_value;
		k = 0;
		while (irq !== 1'b1 && k < 16) begin
			@(posedge clock);
			#1 k++;
		end
	endtask
	task automatic t_regs();
		rd(TMCC_ADDR_CTRL_B);
		chk("ctrl_b reset", {8'h00, rv}, 16'h0000);
		wr(TMCC_ADDR_CTRL_B, 8'hf8);
		rd(TMCC_ADDR_CTRL_B);
		chk("ctrl_b", {8'h00, rv}, 16'h00d8);
		rd(8'h92);
		chk("unmapped", {8'h00, rv}, 16'h0000);
	endtask
	task automatic t_clocks();
		int dv [6] = '{0, 1, 8, 64, 256, 1024};
		for (int i = 0; i < 8; i++) begin
			setm(4'h0, i[2:0], 2'h0);
			#1 c0 = count_value;
			@(posedge clock);
			ext_run <= i > 5;
			// Window of exactly four periods: four ticks at any prescaler phase
			repeat (i > 5 ? 36 : (i == 0 ? 40 : 4 * dv[i] - 2)) @(posedge clock);
			ext_run <= 1'b0;
			repeat (i > 5 ? 6 : 1) @(posedge clock);
			#1 chk("ticks", count_value - c0, i > 5 ? 6 : (i > 0 ? 4 : 0));
		end
	endtask
	task automatic t_capture();
		logic [15:0] cv;
		int          n0;
		wr(TMCC_ADDR_MASK, 8'h21);
		for (int e = 0; e < 2; e++) begin
			setm(4'h0, TMCC_CS_DIV1, {1'b0, e[0]});
			wr(TMCC_ADDR_STATUS, 8'h21);
			drive(!e[0], n0);
			chk("wrong edge", {15'h0, irq}, 16'h0000);
			drive(e[0], n0);
			chk("capture irq", {15'h0, irq}, 16'h0001);
			rd(TMCC_ADDR_CAP_L);
			cv[7:0] = rv;
			rd(TMCC_ADDR_CAP_H);
			cv[15:8] = rv;
			chk("capture value", {15'h0, (cv - c0) <= n0}, 16'h0001);
			setm(4'h0, TMCC_CS_DIV1, {1'b1, e[0]});
			drive(!e[0], n);
			wr(TMCC_ADDR_STATUS, 8'h21);
			@(posedge clock);
			cap_level <= e[0];
			repeat (3) @(posedge clock);
			cap_level <= !e[0];
			repeat (12) @(posedge clock);
			#1 chk("glitch", {15'h0, irq}, 16'h0000);
			drive(e[0], n);
			chk("filter delay", n - n0, 16'h0004);
			drive(!e[0], n);
		end
		wr(TMCC_ADDR_MASK, 8'h00);
		wr(TMCC_ADDR_STATUS, 8'h21);
		drive(1'b1, n);
		chk("masked irq", {15'h0, irq}, 16'h0000);
		rd(TMCC_ADDR_STATUS);
		chk("capture flag", {8'h00, rv & 8'h20}, 16'h0020);
		wr(TMCC_ADDR_STATUS, 8'h20);
		rd(TMCC_ADDR_STATUS);
		chk("flag clear", {8'h00, rv & 8'h20}, 16'h0000);
	endtask
	task automatic t_cap_top();
		wr(TMCC_ADDR_CAP_H, 8'h00);
		wr(TMCC_ADDR_CAP_L, 8'h40);
		setm(4'he, TMCC_CS_DIV1, 2'h1);
		drive(1'b0, n);
		drive(1'b1, n);
		repeat (200) @(posedge clock);
		#1 chk("top cap", {15'h0, count_value <= 16'h0040}, 16'h0001);
		rd(TMCC_ADDR_CAP_L);
		chk("capture off", {8'h00, rv}, 16'h0040);
	endtask
	task automatic t_modes();
		logic [3:0]  m [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
			4'h9, 4'hb, 4'hf};
		logic [15:0] t [10] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h0030,
			16'h00ff, 16'h01ff, 16'h03ff, 16'h0030, 16'h0030, 16'h0030};
		logic [15:0] top;
		setm(4'h0, TMCC_CS_STOP, 2'h0);
		wr(TMCC_ADDR_CMPA_H, 8'h00);
		wr(TMCC_ADDR_CMPA_L, 8'h30);
		@(posedge clock);
		#1 chk("cmp now", compare_active, 16'h0030);
		for (int i = 0; i < 10; i++) begin
			setm(m[i], TMCC_CS_DIV1, 2'h0);
			top = 16'h0000;
			repeat (2100) begin
				@(posedge clock);
				#1 top = count_value > top ? count_value : top;
			end
			chk("top", top, t[i]);
		end
		setm(4'h5, TMCC_CS_DIV1, 2'h0);
		wr(TMCC_ADDR_STATUS, 8'h21);
		repeat (32) @(posedge clock);
		wr(TMCC_ADDR_CMPA_L, 8'h55);
		#1 chk("cmp held", compare_active, 16'h0030);
		repeat (256) @(posedge clock);
		#1 chk("cmp bottom", compare_active, 16'h0055);
		rd(TMCC_ADDR_STATUS);
		chk("overflow", {8'h00, rv & 8'h01}, 16'h0001);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		t_regs();
		t_clocks();
		t_capture();
		t_cap_top();
		t_modes();
		final_report();
	end
endmodule
`default_nettype wire
